/* File: src/timer_pwm_channel_pair.sv */
// Purpose: Two-channel PWM with shared time base, prescaler and APB registers
// Assumes: All inputs synchronous to ref_clk; pclk sampled as a level
// Notes:   Compare channels live elsewhere; only force pulses leave here
//
// Summary of operation
// R1 - Force-select drives pin as discrete output
// R2 - Forced level beats clock output on A
// R3 - Clock-output enable puts count clock on A
// R4 - Select codes pick divide 2..128 or external
// R5 - Channel A period 256 or 32768 increments
// R6 - Channel B period independent, same choices
// R7 - Forced-level bit gives pin zero or one
// R8 - Duty value sets high time per period
// R9 - Duty copied to shadow at cycle end
// R10 - Shadows read-only, zero after reset
// R11 - One shared 16-bit counter for both
// R12 - Prescaler count readable in bits 8:0
// R13 - Prescaler bits 15:9 read zero
// R14 - High while scaled position below shadow
// R15 - Force-compare write of 1 pulses action
//
// Our own choices: the APB slave port and the register addresses.

`timescale 1ns/1ps
`default_nettype none

module timer_pwm_channel_pair (
  input  wire logic                                 ref_clk,
  input  wire logic                                 srst,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [timer_pwm_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [31:0]                          pwdata,
  input  wire logic [3:0]                           pstrb,
  output logic [31:0]                               prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire logic                                 pclkExt,
  output logic                                      pwmPinA,
  output logic                                      pwmPinB,
  output logic [timer_pwm_pkg::FOC_W-1:0]           forceCompareAction
);
  import timer_pwm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // One-cycle tick of the selected count clock
  function automatic logic tapTick(input logic [8:0] pre, input logic [2:0] sel,
                                   input logic extRise);
    logic [7:0] mask;
    mask = 8'hFF >> (3'h7 - sel);
    if (sel == CSEL_EXT) begin
      tapTick = extRise;
    end else begin
      tapTick = ((pre[7:0] & mask) == mask);
    end
  endfunction

  // Period position scaled to 8 bits
  function automatic logic [7:0] periodPos(input logic [15:0] cnt, input logic slow);
    if (slow) begin
      periodPos = cnt[SLOW_POS_LO +: DUTY_W];
    end else begin
      periodPos = cnt[7:0];
    end
  endfunction

  // Last count of a period
  function automatic logic periodLast(input logic [15:0] cnt, input logic slow);
    if (slow) begin
      periodLast = ((cnt & SLOW_LAST) == SLOW_LAST);
    end else begin
      periodLast = ((cnt & FAST_LAST) == FAST_LAST);
    end
  endfunction

  // One byte lane of one register written in the access phase
  function automatic logic regWrite(input logic acc, input logic lane,
                                    input logic [9:0] idx, input logic [9:0] want);
    regWrite = acc && lane && (idx == want);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic                forceSelectA;
  logic                forceSelectB;
  logic                countClockOutEnable;
  logic [2:0]          pwmClockSelect;
  logic                slowFastA;
  logic                slowFastB;
  logic                forcedLevelA;
  logic                forcedLevelB;
  logic [DUTY_W-1:0]   pwmDutyA;
  logic [DUTY_W-1:0]   pwmDutyB;
  logic [DUTY_W-1:0]   pwmDutyShadowA;
  logic [DUTY_W-1:0]   pwmDutyShadowB;
  logic [COUNT_W-1:0]  pwmTimeBaseCount;
  logic [PRESC_W-1:0]  prescalerCount;
  logic                pclkLast;
  logic                countTick;
  logic                pclkRise;
  logic                countClock;

  logic [9:0]          regIdx;
  logic                idxHit;
  logic                wrAccess;
  logic                wrCtlLow;
  logic                wrCtlHigh;
  logic                wrDutyA;
  logic                wrDutyB;
  logic                loadShadowA;
  logic                loadShadowB;
  logic                next_pwmPinA;
  logic                next_pwmPinB;
  logic [31:0]         next_prdata;

  assign regIdx   = paddr[ADDR_W-1:2];
  assign wrAccess = psel && penable && pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Write strobes

  // Lane 1 carries the force bits; lane 0 the rest of the control word
  assign wrCtlLow  = regWrite(wrAccess, pstrb[0], regIdx, IDX_FORCE_AND_PWM_CTRL);
  assign wrCtlHigh = regWrite(wrAccess, pstrb[1], regIdx, IDX_FORCE_AND_PWM_CTRL);
  assign wrDutyA   = regWrite(wrAccess, pstrb[0], regIdx, IDX_PWM_DUTY_A);
  assign wrDutyB   = regWrite(wrAccess, pstrb[0], regIdx, IDX_PWM_DUTY_B);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  always_comb begin
    idxHit      = 1'b1;
    next_prdata = 32'h0000_0000;
    case (regIdx)
      IDX_FORCE_AND_PWM_CTRL: begin
        next_prdata[FSEL_A_BIT]        = forceSelectA;
        next_prdata[FSEL_B_BIT]        = forceSelectB;
        next_prdata[CLKOUT_BIT]        = countClockOutEnable;
        next_prdata[CSEL_HI:CSEL_LO]   = pwmClockSelect;
        next_prdata[SF_A_BIT]          = slowFastA;
        next_prdata[SF_B_BIT]          = slowFastB;
        next_prdata[FLVL_A_BIT]        = forcedLevelA;
        next_prdata[FLVL_B_BIT]        = forcedLevelB;
      end
      IDX_PWM_DUTY_A:         next_prdata[7:0]  = pwmDutyA;
      IDX_PWM_DUTY_B:         next_prdata[7:0]  = pwmDutyB;
      IDX_PWM_TIME_BASE:      next_prdata[15:0] = pwmTimeBaseCount;
      IDX_PWM_SHADOW_A:       next_prdata[7:0]  = pwmDutyShadowA;      // [R10]
      IDX_PWM_SHADOW_B:       next_prdata[7:0]  = pwmDutyShadowB;      // [R10]
      IDX_PRESCALER_READBACK: next_prdata[8:0]  = prescalerCount;      // [R12] [R13]
      default:                idxHit = 1'b0;
    endcase
  end

  // Zero wait states; read data captured in the setup cycle
  assign pready  = READY_LEVEL;
  assign pslverr = psel && penable && !idxHit;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      forceSelectA <= 1'b0;
      forceSelectB <= 1'b0;
    end else if (wrCtlHigh) begin
      forceSelectA <= pwdata[FSEL_A_BIT];
      forceSelectB <= pwdata[FSEL_B_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      countClockOutEnable <= 1'b0;
      pwmClockSelect      <= 3'h0;
      slowFastA           <= 1'b0;
      slowFastB           <= 1'b0;
      forcedLevelA        <= 1'b0;
      forcedLevelB        <= 1'b0;
    end else if (wrCtlLow) begin
      countClockOutEnable <= pwdata[CLKOUT_BIT];
      pwmClockSelect      <= pwdata[CSEL_HI:CSEL_LO];
      slowFastA           <= pwdata[SF_A_BIT];
      slowFastB           <= pwdata[SF_B_BIT];
      forcedLevelA        <= pwdata[FLVL_A_BIT];
      forcedLevelB        <= pwdata[FLVL_B_BIT];
    end
  end

  // Force-compare bits are write-only pulses; zeros do nothing
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      forceCompareAction <= '0;
    end else if (wrCtlHigh) begin
      forceCompareAction <= pwdata[FOC_HI:FOC_LO];                      // [R15]
    end else begin
      forceCompareAction <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty registers

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwmDutyA <= DUTY_RESET;
    end else if (wrDutyA) begin
      pwmDutyA <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwmDutyB <= DUTY_RESET;
    end else if (wrDutyB) begin
      pwmDutyB <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and count clock

  // Free-running; only reset clears it, software cannot
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prescalerCount <= PRESC_RESET;                                   // [R12]
    end else begin
      prescalerCount <= prescalerCount + 9'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pclkLast <= 1'b0;
    end else begin
      pclkLast <= pclkExt;
    end
  end

  assign pclkRise  = pclkExt && !pclkLast;
  assign countTick = tapTick(prescalerCount, pwmClockSelect, pclkRise);   // [R4]

  // Square wave of the selected tap, for the clock-out option
  always_comb begin
    if (pwmClockSelect == CSEL_EXT) begin
      countClock = pclkLast;                                           // [R4]
    end else begin
      countClock = prescalerCount[pwmClockSelect];                     // [R4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared time base

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwmTimeBaseCount <= COUNT_RESET;
    end else if (countTick) begin
      pwmTimeBaseCount <= pwmTimeBaseCount + 16'h0001;                 // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shadow duty

  // Loading only at period end keeps a mid-period write from glitching
  assign loadShadowA = countTick && periodLast(pwmTimeBaseCount, slowFastA);  // [R9] [R5]
  assign loadShadowB = countTick && periodLast(pwmTimeBaseCount, slowFastB);  // [R9] [R6]

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwmDutyShadowA <= SHADOW_RESET;                                  // [R10]
    end else if (loadShadowA) begin
      pwmDutyShadowA <= pwmDutyA;                                      // [R9]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwmDutyShadowB <= SHADOW_RESET;                                  // [R10]
    end else if (loadShadowB) begin
      pwmDutyShadowB <= pwmDutyB;                                      // [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  logic waveA;
  logic waveB;

  // Duty 00 never high; FF high for 255 of 256 steps
  assign waveA = periodPos(pwmTimeBaseCount, slowFastA) < pwmDutyShadowA;  // [R14] [R8] [R5]
  assign waveB = periodPos(pwmTimeBaseCount, slowFastB) < pwmDutyShadowB;  // [R14] [R8] [R6]

  // Force beats clock out, so a forced pin never shows the tap
  always_comb begin
    if (forceSelectA) begin
      next_pwmPinA = forcedLevelA;                                     // [R1] [R2] [R7]
    end else if (countClockOutEnable) begin
      next_pwmPinA = countClock;                                       // [R3]
    end else begin
      next_pwmPinA = waveA;                                            // [R3]
    end
  end

  always_comb begin
    if (forceSelectB) begin
      next_pwmPinB = forcedLevelB;                                     // [R1] [R7]
    end else begin
      next_pwmPinB = waveB;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin registers

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwmPinA <= 1'b0;
    end else begin
      pwmPinA <= next_pwmPinA;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwmPinB <= 1'b0;
    end else begin
      pwmPinB <= next_pwmPinB;
    end
  end

endmodule

`default_nettype wire

/* File: src/timer_pwm_pkg.sv */
// Purpose: Constants for the two-channel timer PWM block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Byte address of a register is four times its index

package timer_pwm_pkg;

  // Register indices; byte address = index * 4
  localparam int unsigned ADDR_W                 = 12;
  localparam logic [9:0]  IDX_FORCE_AND_PWM_CTRL = 10'h124;
  localparam logic [9:0]  IDX_PWM_DUTY_A         = 10'h126;
  localparam logic [9:0]  IDX_PWM_DUTY_B         = 10'h127;
  localparam logic [9:0]  IDX_PWM_TIME_BASE      = 10'h128;
  localparam logic [9:0]  IDX_PWM_SHADOW_A       = 10'h12A;
  localparam logic [9:0]  IDX_PWM_SHADOW_B       = 10'h12B;
  localparam logic [9:0]  IDX_PRESCALER_READBACK = 10'h12C;

  // Control register field positions
  localparam int unsigned FOC_HI      = 15;
  localparam int unsigned FOC_LO      = 11;
  localparam int unsigned FOC_W       = 5;
  localparam int unsigned FSEL_A_BIT  = 9;
  localparam int unsigned FSEL_B_BIT  = 8;
  localparam int unsigned CLKOUT_BIT  = 7;
  localparam int unsigned CSEL_HI     = 6;
  localparam int unsigned CSEL_LO     = 4;
  localparam int unsigned SF_A_BIT    = 3;
  localparam int unsigned SF_B_BIT    = 2;
  localparam int unsigned FLVL_A_BIT  = 1;
  localparam int unsigned FLVL_B_BIT  = 0;

  // Widths and reset values
  localparam int unsigned DUTY_W       = 8;
  localparam int unsigned COUNT_W      = 16;
  localparam int unsigned PRESC_W      = 9;
  localparam logic [7:0]  DUTY_RESET   = 8'h00;
  localparam logic [7:0]  SHADOW_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [8:0]  PRESC_RESET  = 9'h000;
  localparam logic [2:0]  CSEL_EXT     = 3'h7;

  // Period terminals: fast = 256 increments, slow = 32768 increments
  localparam logic [15:0] FAST_LAST    = 16'h00FF;
  localparam logic [15:0] SLOW_LAST    = 16'h7FFF;
  localparam int unsigned SLOW_POS_LO  = 7;

  // APB answer timing: read data is prepared in the setup cycle
  localparam logic        READY_LEVEL  = 1'b1;

endpackage

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the PWM channel pair
// Assumes: Zero-wait APB slave
// Notes:   Full slow periods too long; slow mode seen at low counts
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import timer_pwm_pkg::*;
  logic              ref_clk = 1'b0;
  logic              srst = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [3:0]        pstrb = 4'hF;
  logic              pclkExt = 1'b0;
  logic [31:0]       prdata;
  logic              pready, pslverr, pwmPinA, pwmPinB;
  logic [FOC_W-1:0]  forceCompareAction;
  logic [15:0]       n = '0;
  logic [32:0]       expQ[$];
  logic [32:0]       r;
  logic [31:0]       v;
  logic [7:0]        d, dB, prev;
  logic [9:0]        ro[5] = '{IDX_PWM_SHADOW_A, IDX_PWM_SHADOW_B, IDX_PRESCALER_READBACK,
                               10'h125, IDX_PWM_TIME_BASE};
  int                nFail = 0;
  int                totalChecks = 0;
  int                seed = 32'h27CC;
  timer_pwm_channel_pair u_timer_pwm_channel_pair (
    .ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .pclkExt, .pwmPinA, .pwmPinB, .forceCompareAction
  );
  always #2.5 ref_clk = ~ref_clk;
  // Mirror of the prescaler; external clock of period 8
  always @(posedge ref_clk) begin
    n <= srst ? 16'h0000 : n + 16'h0001;
    pclkExt <= n[2];
  end
  ////////////////////////////////////////
  task automatic chk(input logic [32:0] e, input logic [32:0] g);
    totalChecks++;
    if (g !== e) begin
      nFail++;
      $display("unexpected t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd,
                     input logic [32:0] e);
    @(posedge ref_clk);
    if (!w && idx == IDX_PRESCALER_READBACK) e[8:0] = n[8:0] + 9'h001;
    // Valid only while the select still holds divide by 2 from reset
    if (!w && idx == IDX_PWM_TIME_BASE) e[15:0] = (n + 16'h0001) >> 1;
    expQ.push_back(e);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bus results, compared in order of issue
  always @(posedge ref_clk) begin
    if (psel && penable && pready) chk(expQ.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
  end
  // Toggles and high cycles over 512 clocks, packed
  task automatic meas(output logic [32:0] m);
    int   t, hA, hB;
    logic last;
    t = 0;
    hA = 0;
    hB = 0;
    last = pwmPinA;
    repeat (512) begin
      @(posedge ref_clk);
      t += int'(pwmPinA != last);
      hA += int'(pwmPinA);
      hB += int'(pwmPinB);
      last = pwmPinA;
    end
    m = {3'h0, 10'(t), 10'(hA), 10'(hB)};
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #150000;
    nFail++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    apb(0, IDX_FORCE_AND_PWM_CTRL, '0, '0);
    apb(0, IDX_PWM_DUTY_A, '0, '0);
    apb(0, IDX_PWM_DUTY_B, '0, '0);
    // Read-only writes dropped, unmapped place flagged
    foreach (ro[i]) begin
      apb(1, ro[i], 32'hFFFF, {ro[i] == 10'h125, 32'h0});
      apb(0, ro[i], '0, {ro[i] == 10'h125, 32'h0});
    end
    for (int i = 0; i < 5; i++) begin
      v = $random(seed) & 32'h3FF | 32'h800 << i;
      apb(1, IDX_FORCE_AND_PWM_CTRL, v, '0);
      repeat (4) @(posedge ref_clk);
      apb(0, IDX_FORCE_AND_PWM_CTRL, '0, {1'b0, v & 32'h3FF});
    end
    for (int l = 0; l < 4; l++) begin
      apb(1, IDX_FORCE_AND_PWM_CTRL, 32'h380 | l, '0);
      repeat (4) @(posedge ref_clk);
      chk({31'h0, 2'(l)}, {31'h0, pwmPinA, pwmPinB});
    end
    for (int k = 0; k < 8; k++) begin
      apb(1, IDX_FORCE_AND_PWM_CTRL, 32'h80 | k << 4, '0);
      repeat (4) @(posedge ref_clk);
      meas(r);
      chk({3'h0, k < 7 ? 10'h200 >> k : 10'h080, 10'h100, 10'h000}, r);
    end
    apb(1, IDX_FORCE_AND_PWM_CTRL, '0, '0);
    prev = 8'h00;
    // Zero last: a period start is needed to time the shadow read
    for (int j = 0; j < 4; j++) begin
      d = j == 0 ? 8'h80 : j == 1 ? 8'hFF : j == 2 ? 8'($random(seed)) : 8'h00;
      dB = 8'($random(seed));
      if (prev != 8'h00) @(posedge pwmPinA);
      apb(1, IDX_PWM_DUTY_A, {24'h0, d}, '0);
      apb(1, IDX_PWM_DUTY_B, {24'h0, dB}, '0);
      if (prev != 8'h00) apb(0, IDX_PWM_SHADOW_A, '0, {25'h0, prev});
      repeat (520) @(posedge ref_clk);
      apb(0, IDX_PWM_DUTY_A, '0, {25'h0, d});
      apb(0, IDX_PWM_SHADOW_A, '0, {25'h0, d});
      meas(r);
      chk({3'h0, 10'(d != 8'h00 ? 2 : 0), 10'(2 * d), 10'(2 * dB)}, r);
      prev = d;
    end
    // Slow A at a low count stays high at 80; B keeps the fast rate
    apb(1, IDX_PWM_DUTY_A, 32'h80, '0);
    apb(1, IDX_PWM_DUTY_B, 32'h80, '0);
    repeat (520) @(posedge ref_clk);
    apb(1, IDX_FORCE_AND_PWM_CTRL, 32'h8, '0);
    repeat (4) @(posedge ref_clk);
    meas(r);
    chk({3'h0, 10'h000, 10'h200, 10'h100}, r);
    summarize();
  end
endmodule
`default_nettype wire

/* File: tb/timer_pwm_monitor.sv */
// Purpose: Port checks for the PWM channel pair
// Assumes: Control mirrored from APB writes
// Notes:   Pins lag the control by one clock
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_monitor
  import timer_pwm_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              srst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pwmPinA,
  input wire logic              pwmPinB,
  input wire logic [FOC_W-1:0]  forceCompareAction
);
  logic [9:0] ctl, c1, c2, c3;
  logic       wrCtl, wrFoc, steady;
  assign wrCtl  = psel && penable && pwrite && paddr[11:2] == IDX_FORCE_AND_PWM_CTRL;
  assign wrFoc  = wrCtl && pstrb[1];
  // Four quiet cycles so pin history is fully settled
  assign steady = ctl == c1 && c1 == c2 && c2 == c3;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctl <= 10'h000;
    end else if (wrCtl) begin
      if (pstrb[1]) ctl[9:8] <= pwdata[9:8];
      if (pstrb[0]) ctl[7:0] <= pwdata[7:0];
    end
  end
  always_ff @(posedge ref_clk) begin
    c1 <= ctl;
    c2 <= c1;
    c3 <= c2;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_foc_pulse;
    wrFoc |=> forceCompareAction == $past(pwdata[15:11]);
  endproperty
  a_foc_pulse: assert property (p_foc_pulse) else $error("force pulse wrong");
  property p_foc_cause;
    |forceCompareAction |-> $past(wrFoc);
  endproperty
  a_foc_cause: assert property (p_foc_cause) else $error("stray force pulse");
  property p_force_a;
    steady && ctl[9] |-> pwmPinA == ctl[1];
  endproperty
  a_force_a: assert property (p_force_a) else $error("pin A not forced");
  property p_force_b;
    steady && ctl[8] |-> pwmPinB == ctl[0];
  endproperty
  a_force_b: assert property (p_force_b) else $error("pin B not forced");
  property p_force_clk;
    steady && ctl[9] && ctl[7] |-> $stable(pwmPinA);
  endproperty
  a_force_clk: assert property (p_force_clk) else $error("clock leaks past force");
  property p_clk_div2;
    steady && !ctl[9] && ctl[7] && ctl[6:4] == 3'h0 |-> pwmPinA != $past(pwmPinA);
  endproperty
  a_clk_div2: assert property (p_clk_div2) else $error("divide by 2 wrong");
  property p_clk_div4;
    steady && !ctl[9] && ctl[7] && ctl[6:4] == 3'h1 |-> pwmPinA != $past(pwmPinA, 2);
  endproperty
  a_clk_div4: assert property (p_clk_div4) else $error("divide by 4 wrong");
  property p_presc_top;
    psel && penable && !pwrite && paddr[11:2] == IDX_PRESCALER_READBACK |-> prdata[31:9] == '0;
  endproperty
  a_presc_top: assert property (p_presc_top) else $error("prescaler top bits set");
endmodule
bind timer_pwm_channel_pair timer_pwm_monitor u_timer_pwm_monitor (
  .ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pwmPinA, .pwmPinB, .forceCompareAction
);
`default_nettype wire
